// >>> verilog/arir_pkg.sv
// Package with register map, field layout and constants of the result block.
package arir_pkg;
	localparam int NCH = 8;
	localparam int DW  = 10;
	localparam int AW  = 32;
	localparam logic [AW-1:0] OFS_LAST_RESULT  = 32'h400ac020;
	localparam logic [AW-1:0] OFS_IRQ_EN_SET   = 32'h400ac024;
	localparam logic [AW-1:0] OFS_IRQ_EN_CLR   = 32'h400ac028;
	localparam logic [AW-1:0] OFS_IRQ_MASK     = 32'h400ac02c;
	localparam logic [AW-1:0] OFS_CH_RESULT    = 32'h400ac030;
	localparam logic [AW-1:0] OFS_CONV_STATUS  = 32'h400ac01c;
	localparam logic [AW-1:0] OFS_CH_ENABLE    = 32'h400ac010;
	localparam logic [AW-1:0] OFS_CH_DISABLE   = 32'h400ac014;
	localparam logic [AW-1:0] OFS_CH_STATUS    = 32'h400ac018;
	localparam logic [AW-1:0] OFS_IRQ_STAT     = 32'h400ac0f0;
	localparam logic [AW-1:0] OFS_IRQ_STAT_CLR = 32'h400ac0f4;
	localparam logic [AW-1:0] OFS_IRQ_STAT_EN  = 32'h400ac0f8;
	localparam int WORD_BYTES = 4;
	localparam int EOC_LSB = 0;
	localparam int OVR_LSB = 8;
	localparam int RESULT_READY_FLAG_BIT   = 16;
	localparam int GENERAL_OVERRUN_FLAG_BIT  = 17;
	localparam int BUFFER_END_FLAG_BIT  = 18;
	localparam int BUFFER_FULL_FLAG_BIT = 19;
	localparam int NSRC = 20;
	localparam int NEVT = 3;
	localparam int EVT_DONE  = 0;
	localparam int EVT_OVR   = 1;
	localparam int EVT_GENERAL_OVERRUN_FLAG = 2;
	localparam logic [31:0] ZERO32 = 32'h0;
	localparam logic [NSRC-1:0] MASK_RST = 20'h0;
	localparam logic [DW-1:0] DATA_RST = 10'h0;
	localparam logic [NCH-1:0] CH_RST = 8'h0;
	typedef enum logic [1:0] {ARIR_IDLE, ARIR_HELD} arir_hold_t;
endpackage : arir_pkg

// >>> verilog/arir_chan.sv
// One channel result register with its end-of-conversion and overrun flags.
`timescale 1ns/1ns
module arir_chan
	import arir_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          done,
	input  wire logic          enabled,
	input  wire logic [DW-1:0] data,
	input  wire logic          rd_data,
	input  wire logic          rd_status,
	output logic      [DW-1:0] result_r,
	output logic               eoc_r,
	output logic               ovr_r
);
	logic load;
	assign load = done & enabled;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			result_r <= DATA_RST;
		end else if (load) begin // [RQ5]
			result_r <= data;
		end
	end

	// A new result sets the flag even in the cycle the old one is read.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eoc_r <= 1'b0;
		end else if (load) begin
			eoc_r <= 1'b1;
		end else if (rd_data || !enabled) begin
			eoc_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovr_r <= 1'b0;
		end else if (load && eoc_r) begin // [RQ8]
			ovr_r <= 1'b1;
		end else if (rd_status) begin // [RQ8]
			ovr_r <= 1'b0;
		end
	end
endmodule // arir_chan

// >>> verilog/arir_evt.sv
// Sticky event status bits with enable and write-one-to-clear.
`timescale 1ns/1ns
module arir_evt
	import arir_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            arst_n,
	input  wire logic [NEVT-1:0] evt,
	input  wire logic            clr_we,
	input  wire logic            en_we,
	input  wire logic [NEVT-1:0] wdata,
	output logic      [NEVT-1:0] stat_r,
	output logic      [NEVT-1:0] en_r,
	output logic                 pend
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_r <= '0;
		end else begin
			stat_r <= evt | (stat_r & ~(clr_we ? wdata : '0));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_r <= '0;
		end else if (en_we) begin
			en_r <= wdata;
		end
	end

	assign pend = |(stat_r & en_r);
endmodule // arir_evt

// >>> verilog/arir_top.sv
// Result and interrupt registers of an eight-channel converter controller.
// What this block does
// [RQ1] Each finished conversion loads last-result, held until the next one.
// [RQ2] Ones written to the enable-set register set those mask bits.
// [RQ3] Writing ones to the enable-clear register clears those mask bits.
// [RQ4] The mask view register reads one for every enabled interrupt source.
// [RQ5] A channel result loads only while its channel is enabled, and holds.
// [RQ6] Bits 0-7 end, 8-15 overrun, 16-19 ready, general overrun, buffers.
// [RQ7] Result-ready sets on a conversion and clears on a last-result read.
// [RQ8] A channel overrun flag sets on overwrite and clears on a status read.
// [RQ9] The interrupt is high while any flag and its mask bit are both set.
`timescale 1ns/1ns
module arir_top
	import arir_pkg::*;
(
	input  wire logic                 CLK,
	input  wire logic                 ARST_N,
	input  wire logic [AW-1:0]        ADDR,
	input  wire logic [31:0]          WDATA,
	input  wire logic                 WR,
	input  wire logic                 RD,
	output logic      [31:0]          RDATA,
	input  wire logic                 CONV_DONE,
	input  wire logic [2:0]           CONV_CH,
	input  wire logic [DW-1:0]        CONV_DATA,
	input  wire logic                 BUF_END,
	input  wire logic                 BUF_FULL,
	output logic                      IRQ,
	output logic                      EVT_IRQ
);
	function automatic logic hit(input logic [AW-1:0] a,
		input logic [AW-1:0] o);
		hit = (a == o);
	endfunction

	logic [NSRC-1:0] mask_r;
	logic [NCH-1:0]  ch_en_r;
	logic [DW-1:0]   last_r;
	logic            result_ready_flag_r;
	logic            general_overrun_flag_r;
	logic            buffer_end_flag_r;
	logic            buffer_full_flag_r;
	logic [NCH-1:0]  eoc;
	logic [NCH-1:0]  ovr;
	logic [DW-1:0]   ch_res [NCH];
	logic [NSRC-1:0] status;
	logic            rd_status;
	logic            rd_last;
	logic            evt_pend;
	logic [NEVT-1:0] evt_stat;
	logic [NEVT-1:0] evt_en;
	logic [NEVT-1:0] evt;
	logic [2:0]      rd_ch;
	logic            rd_chres;
	logic [31:0]     rdata_nxt;

	assign rd_status = RD & hit(ADDR, OFS_CONV_STATUS);
	assign rd_last   = RD & hit(ADDR, OFS_LAST_RESULT);
	assign rd_chres  = RD && ADDR >= OFS_CH_RESULT &&
		ADDR < OFS_CH_RESULT + AW'(NCH * WORD_BYTES);
	assign rd_ch     = 3'((ADDR - OFS_CH_RESULT) >> $clog2(WORD_BYTES));

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			arir_chan u_chan (
				.clk       (CLK),
				.arst_n    (ARST_N),
				.done      (CONV_DONE && CONV_CH == 3'(g)),
				.enabled   (ch_en_r[g]),
				.data      (CONV_DATA),
				.rd_data   (rd_chres && rd_ch == 3'(g)),
				.rd_status (rd_status),
				.result_r  (ch_res[g]),
				.eoc_r     (eoc[g]),
				.ovr_r     (ovr[g])
			);
		end
	endgenerate

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ch_en_r <= CH_RST;
		end else if (WR && hit(ADDR, OFS_CH_ENABLE)) begin
			ch_en_r <= ch_en_r | WDATA[NCH-1:0];
		end else if (WR && hit(ADDR, OFS_CH_DISABLE)) begin
			ch_en_r <= ch_en_r & ~WDATA[NCH-1:0];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			last_r <= DATA_RST;
		end else if (CONV_DONE) begin // [RQ1]
			last_r <= CONV_DATA;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			result_ready_flag_r <= 1'b0;
		end else if (CONV_DONE) begin // [RQ7]
			result_ready_flag_r <= 1'b1;
		end else if (rd_last) begin // [RQ7]
			result_ready_flag_r <= 1'b0;
		end
	end

	// General overrun: a new result replaces a last result never read.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			general_overrun_flag_r <= 1'b0;
		end else if (CONV_DONE && result_ready_flag_r) begin
			general_overrun_flag_r <= 1'b1;
		end else if (rd_status) begin
			general_overrun_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			buffer_end_flag_r  <= 1'b0;
			buffer_full_flag_r <= 1'b0;
		end else begin
			buffer_end_flag_r  <= BUF_END;
			buffer_full_flag_r <= BUF_FULL;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mask_r <= MASK_RST;
		end else if (WR && hit(ADDR, OFS_IRQ_EN_SET)) begin // [RQ2]
			mask_r <= mask_r | WDATA[NSRC-1:0];
		end else if (WR && hit(ADDR, OFS_IRQ_EN_CLR)) begin // [RQ3]
			mask_r <= mask_r & ~WDATA[NSRC-1:0];
		end
	end

	always_comb begin
		status = '0;
		status[EOC_LSB +: NCH] = eoc; // [RQ6]
		status[OVR_LSB +: NCH] = ovr; // [RQ6]
		status[RESULT_READY_FLAG_BIT]       = result_ready_flag_r;
		status[GENERAL_OVERRUN_FLAG_BIT]      = general_overrun_flag_r;
		status[BUFFER_END_FLAG_BIT]      = buffer_end_flag_r;
		status[BUFFER_FULL_FLAG_BIT]     = buffer_full_flag_r;
	end

	assign evt[EVT_DONE]  = CONV_DONE;
	assign evt[EVT_OVR]   = CONV_DONE && eoc[CONV_CH];
	assign evt[EVT_GENERAL_OVERRUN_FLAG] = CONV_DONE && result_ready_flag_r;

	arir_evt u_evt (
		.clk    (CLK),
		.arst_n (ARST_N),
		.evt    (evt),
		.clr_we (WR && hit(ADDR, OFS_IRQ_STAT_CLR)),
		.en_we  (WR && hit(ADDR, OFS_IRQ_STAT_EN)),
		.wdata  (WDATA[NEVT-1:0]),
		.stat_r (evt_stat),
		.en_r   (evt_en),
		.pend   (evt_pend)
	);

	always_comb begin
		rdata_nxt = ZERO32;
		if (rd_last) begin
			rdata_nxt = 32'(last_r); // [RQ9]
		end else if (RD && hit(ADDR, OFS_IRQ_MASK)) begin
			rdata_nxt = 32'(mask_r); // [RQ4]
		end else if (rd_status) begin
			rdata_nxt = 32'(status);
		end else if (RD && hit(ADDR, OFS_CH_STATUS)) begin
			rdata_nxt = 32'(ch_en_r);
		end else if (rd_chres) begin
			rdata_nxt = 32'(ch_res[rd_ch]); // [RQ9]
		end else if (RD && hit(ADDR, OFS_IRQ_STAT)) begin
			rdata_nxt = 32'(evt_stat);
		end else if (RD && hit(ADDR, OFS_IRQ_STAT_EN)) begin
			rdata_nxt = 32'(evt_en);
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= ZERO32;
		end else begin
			RDATA <= rdata_nxt;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			IRQ     <= 1'b0;
			EVT_IRQ <= 1'b0;
		end else begin
			IRQ     <= |(status & mask_r); // [RQ9]
			EVT_IRQ <= evt_pend;
		end
	end

	property p_last;
		@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE |=> last_r == $past(CONV_DATA);
	endproperty
	a_last: assert property (p_last) // [RQ1]
		else $error("last result not loaded");
	property p_last_hold;
		@(posedge CLK) disable iff (!ARST_N)
		!CONV_DONE |=> $stable(last_r);
	endproperty
	a_last_hold: assert property (p_last_hold) // [RQ1]
		else $error("last result moved");
	property p_set;
		@(posedge CLK) disable iff (!ARST_N)
		WR && ADDR == OFS_IRQ_EN_SET |=>
			(mask_r & $past(WDATA[NSRC-1:0])) == $past(WDATA[NSRC-1:0]);
	endproperty
	a_set: assert property (p_set) // [RQ2]
		else $error("mask set failed");
	property p_set_keep;
		@(posedge CLK) disable iff (!ARST_N)
		WR && ADDR == OFS_IRQ_EN_SET |=>
			(mask_r & ~$past(WDATA[NSRC-1:0])) ==
			($past(mask_r) & ~$past(WDATA[NSRC-1:0]));
	endproperty
	a_set_keep: assert property (p_set_keep) // [RQ2]
		else $error("mask set disturbed other bits");
	property p_clr;
		@(posedge CLK) disable iff (!ARST_N)
		WR && ADDR == OFS_IRQ_EN_CLR |=>
			(mask_r & $past(WDATA[NSRC-1:0])) == '0;
	endproperty
	a_clr: assert property (p_clr) // [RQ3]
		else $error("mask clear failed");
	property p_clr_keep;
		@(posedge CLK) disable iff (!ARST_N)
		WR && ADDR == OFS_IRQ_EN_CLR |=>
			(mask_r | $past(WDATA[NSRC-1:0])) ==
			($past(mask_r) | $past(WDATA[NSRC-1:0]));
	endproperty
	a_clr_keep: assert property (p_clr_keep) // [RQ3]
		else $error("mask clear disturbed other bits");
	property p_mread;
		@(posedge CLK) disable iff (!ARST_N)
		RD && ADDR == OFS_IRQ_MASK |=> RDATA == 32'($past(mask_r));
	endproperty
	a_mread: assert property (p_mread) // [RQ4]
		else $error("mask read wrong");
	property p_chres;
		@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE && ch_en_r[CONV_CH] |=>
			ch_res[$past(CONV_CH)] == $past(CONV_DATA);
	endproperty
	a_chres: assert property (p_chres) // [RQ5]
		else $error("enabled channel not loaded");
	property p_chdis;
		@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE && !ch_en_r[CONV_CH] |=>
			ch_res[$past(CONV_CH)] == $past(ch_res[CONV_CH]);
	endproperty
	a_chdis: assert property (p_chdis) // [RQ5]
		else $error("disabled channel loaded");
	property p_layout;
		@(posedge CLK) disable iff (!ARST_N)
		rd_status |=>
			RDATA[EOC_LSB +: NCH] == $past(eoc) &&
			RDATA[OVR_LSB +: NCH] == $past(ovr) &&
			RDATA[RESULT_READY_FLAG_BIT] == $past(result_ready_flag_r);
	endproperty
	a_layout: assert property (p_layout) // [RQ6]
		else $error("status layout wrong");
	property p_result_ready_flag_set;
		@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE |=> result_ready_flag_r;
	endproperty
	a_result_ready_flag_set: assert property (p_result_ready_flag_set) // [RQ7]
		else $error("ready flag not set");
	property p_result_ready_flag;
		@(posedge CLK) disable iff (!ARST_N)
		rd_last && !CONV_DONE |=> !result_ready_flag_r;
	endproperty
	a_result_ready_flag: assert property (p_result_ready_flag) // [RQ7]
		else $error("ready flag not cleared");
	property p_ovr;
		@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE && ch_en_r[CONV_CH] && eoc[CONV_CH] |=>
			ovr[$past(CONV_CH)];
	endproperty
	a_ovr: assert property (p_ovr) // [RQ8]
		else $error("overrun not flagged");
	property p_ovr_hold;
		@(posedge CLK) disable iff (!ARST_N)
		!rd_status |=> (ovr & $past(ovr)) == $past(ovr);
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) // [RQ8]
		else $error("overrun flag lost before status read");
	property p_irq;
		@(posedge CLK) disable iff (!ARST_N)
		|(status & mask_r) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) // [RQ9]
		else $error("interrupt missing");
	property p_irq_low;
		@(posedge CLK) disable iff (!ARST_N)
		!(|(status & mask_r)) |=> !IRQ;
	endproperty
	a_irq_low: assert property (p_irq_low) // [RQ9]
		else $error("interrupt without enabled flag");
	property p_upper;
		@(posedge CLK) disable iff (!ARST_N)
		rd_last || rd_chres |=> RDATA[31:DW] == '0;
	endproperty
	a_upper: assert property (p_upper) // [RQ9]
		else $error("result upper bits not zero");

	// Main scenarios that the bench should reach.
	c_conv: cover property (@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE && ch_en_r[CONV_CH]);
	c_ovr: cover property (@(posedge CLK) disable iff (!ARST_N)
		$rose(|ovr));
	c_irq: cover property (@(posedge CLK) disable iff (!ARST_N)
		$rose(IRQ));
	c_general_overrun_flag: cover property (@(posedge CLK) disable iff (!ARST_N)
		CONV_DONE && result_ready_flag_r);
	c_rdclr: cover property (@(posedge CLK) disable iff (!ARST_N)
		rd_last && result_ready_flag_r);
endmodule // arir_top

// >>> tb/arir_core_model.sv
// Conversion core model that hands results to the block one pulse at a time.
`timescale 1ns/1ns
module arir_core_model
	import arir_pkg::*;
(
	input  wire logic          CLK,
	output logic               CONV_DONE,
	output logic [2:0]         CONV_CH,
	output logic [DW-1:0]      CONV_DATA
);
	initial begin
		CONV_DONE = 1'b0;
		CONV_CH = 3'h0;
		CONV_DATA = '0;
	end
	// Waits gap plus one clock edges, then pulses one result; lines show the inverse after.
	task automatic conv(input logic [2:0] c, input logic [DW-1:0] d,
		input int g);
		repeat (g) @(posedge CLK);
		@(posedge CLK);
		CONV_DONE <= 1'b1;
		CONV_CH <= c;
		CONV_DATA <= d;
		@(posedge CLK);
		CONV_DONE <= 1'b0;
		CONV_CH <= ~c;
		CONV_DATA <= ~d;
	endtask
endmodule // arir_core_model

// >>> tb/tb.sv
// Self-checking bench of the result and interrupt register block.
`timescale 1ns/1ns
module tb
	import arir_pkg::*;
;
	logic          clk, arst_n, wr, rd, done, b_end, b_full, irq, evt_irq;
	logic [31:0]   addr, wdata, rdata;
	logic [2:0]    cch;
	logic [DW-1:0] cdat;
	int            num_errors = 0, n_tests = 0, mask = 0, lastv = 0;
	int            res[NCH] = '{default: 0};
	bit [7:0]      en, eoc, ovr;
	bit [2:0]      ev, ev_en;
	bit            result_ready_flag, general_overrun_flag;
	int unsigned   lf_r = 68142;

	arir_top u_dut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CONV_DONE(done), .CONV_CH(cch),
		.CONV_DATA(cdat), .BUF_END(b_end), .BUF_FULL(b_full), .IRQ(irq),
		.EVT_IRQ(evt_irq));
	arir_core_model u_core (.CLK(clk), .CONV_DONE(done), .CONV_CH(cch),
		.CONV_DATA(cdat));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic int unsigned lfsr();
		lf_r = {lf_r[30:0], lf_r[31] ^ lf_r[21] ^ lf_r[1] ^ lf_r[0]};
		return lf_r;
	endfunction

	function automatic int stat();
		return {12'h0, b_full, b_end, general_overrun_flag, result_ready_flag, ovr, eoc};
	endfunction

	function automatic void exp_wr(input logic [31:0] a, input int d);
		case (a)
			OFS_IRQ_EN_SET: mask |= d & 32'h000fffff;
			OFS_IRQ_EN_CLR: mask &= ~d;
			OFS_CH_ENABLE: en |= d[7:0];
			OFS_CH_DISABLE: en &= ~d[7:0];
			OFS_IRQ_STAT_CLR: ev &= ~d[2:0];
			OFS_IRQ_STAT_EN: ev_en = d[2:0];
			default: ;
		endcase
		eoc &= en;
	endfunction

	function automatic int exp_rd(input logic [31:0] a);
		int v;
		int n;
		v = 0;
		n = int'((a - OFS_CH_RESULT) >> 2);
		case (a)
			OFS_IRQ_MASK: v = mask;
			OFS_CH_STATUS: v = en;
			OFS_IRQ_STAT: v = ev;
			OFS_IRQ_STAT_EN: v = ev_en;
			OFS_LAST_RESULT: begin
				v = lastv;
				result_ready_flag = 1'b0;
			end
			OFS_CONV_STATUS: begin
				v = stat();
				ovr = '0;
				general_overrun_flag = 1'b0;
			end
			default: if (a >= OFS_CH_RESULT && n < NCH) begin
				v = res[n];
				eoc[n] = 1'b0;
			end
		endcase
		return v;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wt(input logic [31:0] a, input int d);
		exp_wr(a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rc(input logic [31:0] a);
		int e;
		e = exp_rd(a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("RDATA %h", a), e, rdata);
	endtask

	task automatic chk_irq();
		repeat (3) @(posedge clk);
		#1;
		chk("IRQ", {31'h0, |(stat() & mask)}, {31'h0, irq});
		chk("EVT_IRQ", {31'h0, |(ev & ev_en)}, {31'h0, evt_irq});
	endtask

	task automatic cv(input int g);
		bit [2:0] c;
		bit [DW-1:0] d;
		c = 3'(lfsr());
		d = DW'(lfsr());
		u_core.conv(c, d, g);
		ev[0] = 1'b1;
		ev[2] = ev[2] | result_ready_flag;
		general_overrun_flag = general_overrun_flag | result_ready_flag;
		result_ready_flag = 1'b1;
		lastv = d;
		if (en[c]) begin
			ev[1] = ev[1] | eoc[c];
			ovr[c] = ovr[c] | eoc[c];
			eoc[c] = 1'b1;
			res[c] = d;
		end
		chk_irq();
	endtask

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		wrap_up();
	end

	initial begin
		{arst_n, wr, rd, b_end, b_full} = '0;
		addr = '0;
		wdata = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		chk_irq();
		rc(OFS_IRQ_MASK);
		rc(OFS_IRQ_STAT_EN + 32'h100);
		for (int i = 0; i < 8; i++) begin
			wt(OFS_IRQ_EN_SET, lfsr());
			wt(OFS_IRQ_EN_CLR, lfsr());
			rc(OFS_IRQ_MASK);
		end
		wt(OFS_IRQ_STAT_EN, 7);
		for (int k = 0; k < 24; k++) begin
			if (k % 6 == 0) wt(OFS_CH_ENABLE, lfsr());
			if (k % 6 == 3) wt(OFS_CH_DISABLE, lfsr());
			b_end <= lf_r[3];
			b_full <= lf_r[5];
			cv(k % 3);
			if (k % 2) rc(OFS_LAST_RESULT);
			if (k % 3 == 2) rc(OFS_CONV_STATUS);
			if (k % 4 == 1) rc(OFS_CH_RESULT + 32'(4 * (k % 8)));
			if (k % 8 == 7) wt(OFS_IRQ_STAT_CLR, 7);
			if (k % 5 == 4) wt(OFS_IRQ_EN_SET, lfsr());
			if (k % 5 == 2) wt(OFS_IRQ_EN_CLR, lfsr());
			rc(OFS_CH_STATUS);
			rc(OFS_IRQ_STAT);
			chk_irq();
		end
		for (int c = 0; c < NCH; c++)
			rc(OFS_CH_RESULT + 32'(4 * c));
		wt(OFS_IRQ_STAT_EN, 0);
		chk_irq();
		wt(OFS_IRQ_STAT_EN, 7);
		rc(OFS_IRQ_STAT_EN);
		wt(OFS_IRQ_STAT_CLR, 7);
		chk_irq();
		wrap_up();
	end
endmodule // tb
